// *** pkg/tds_map.svh ***
/*
 Register offsets, field positions, reset values and numeric constants
 of the triangle decomposition and object setup block.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef TDS_MAP_SVH
`define TDS_MAP_SVH

// Register byte offsets and the viewport table page number on the APB bus.
`define TDS_ADDR_CTRL  12'h000
`define TDS_ADDR_STAT  12'h004
`define TDS_VP_PAGE    3'h1
// Control register field positions and reset value.
`define TDS_CTRL_VPEN  0
`define TDS_CTRL_BIAS  1
`define TDS_CTRL_PLS   2
`define TDS_CTRL_PFAN  4
`define TDS_CTRL_RST   6'h00
// Viewport table shape and field widths.
`define TDS_VPW        4
`define TDS_VP_ENTRIES 16
`define TDS_VP_ELEMS   6
`define TDS_ATTRW      16
// Floating-point constants.
`define TDS_FP_QNAN    32'h7FC00000
`define TDS_FP_MHALF   32'hBF000000
`define TDS_FP_BIAS    10'h07F
// Last vertex index of an independent object and object vertex counts.
`define TDS_GRP_LAST   2'h2
`define TDS_NV_TRI     3'h3
`define TDS_NV_RECT    3'h4

`endif

// *** pkg/tds_pkg.sv ***
/*
 Types of the triangle decomposition and object setup block.
 Assumes tds_map.svh is on the include path.
*/
package tds_pkg;
`include "tds_map.svh"

   // Topology codes of an incoming primitive.
   typedef enum logic [2:0] {
      topo_triangle_list, topo_triangle_strip, topo_triangle_strip_rev,
      topo_triangle_fan, topo_fan_no_stipple, topo_polygon,
      topo_rectangle_list
   } tds_topo_t;

   // Kind of basic object handed downstream.
   typedef enum logic {obj_kind_triangle, obj_kind_rectangle} tds_kind_t;

   // One vertex: IEEE single positions, viewport select and attribute handle.
   typedef struct packed {
      logic [31:0]            x;
      logic [31:0]            y;
      logic [31:0]            z;
      logic [31:0]            reciprocal_w;
      logic [`TDS_VPW-1:0]    viewport_select;
      logic [`TDS_ATTRW-1:0]  attr;
   } tds_vtx_t;

   // Input beat: a vertex, its topology and a start-of-primitive mark.
   typedef struct packed {
      logic      first;
      tds_topo_t topo;
      tds_vtx_t  vtx;
   } tds_vin_t;

   // Object handed to the rasterizer stage.
   typedef struct packed {
      tds_kind_t      obj_kind;
      logic [2:0]     obj_vertex_count;
      logic           winding_invert_flag;
      logic           poly_stipple_flag;
      logic [1:0]     provoking_index;
      tds_vtx_t [3:0] v;
   } tds_obj_t;
endpackage

// *** src/tds_fp_mul.sv ***
/*
 Combinational IEEE single multiplier with truncation.
 Assumes subnormals may be flushed to zero; NaN results are quiet.
*/
`timescale 1ns/1ps
`include "tds_map.svh"
module tds_fp_mul (
   // Operands and product.
   input  wire logic [31:0] a,
   input  wire logic [31:0] b,
   output logic      [31:0] y
);
   logic        sy;
   logic [47:0] p;
   logic [9:0]  e;
   logic [22:0] m;
   logic        na, nb, ia, ib, za, zb;

   // Forms the product, normalises it and resolves the special cases.
   always_comb begin
      sy = a[31] ^ b[31];
      na = (a[30:23] == 8'hFF) && (a[22:0] != 23'h0);
      nb = (b[30:23] == 8'hFF) && (b[22:0] != 23'h0);
      ia = (a[30:23] == 8'hFF) && !na;
      ib = (b[30:23] == 8'hFF) && !nb;
      za = (a[30:23] == 8'h00);
      zb = (b[30:23] == 8'h00);
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = {2'h0, a[30:23]} + {2'h0, b[30:23]} - `TDS_FP_BIAS;
      if (p[47]) begin
         m = p[46:24];
         e = e + 10'h001;
      end else begin
         m = p[45:23];
      end
      if (na || nb || (ia && zb) || (za && ib)) begin
         y = `TDS_FP_QNAN;
      end else if (ia || ib || (!za && !zb && !e[9] && e >= 10'h0FF)) begin
         y = {sy, 8'hFF, 23'h0};
      end else if (za || zb || e[9] || e == 10'h000) begin
         y = {sy, 31'h0};
      end else begin
         y = {sy, e[7:0], m};
      end
   end
endmodule

// *** src/tds_fp_add.sv ***
/*
 Combinational IEEE single adder with truncation.
 Assumes subnormals may be flushed to zero; NaN results are quiet.
*/
`timescale 1ns/1ps
`include "tds_map.svh"
module tds_fp_add (
   // Operands and sum.
   input  wire logic [31:0] a,
   input  wire logic [31:0] b,
   output logic      [31:0] y
);
   logic [31:0] big, sml;
   logic [24:0] s, ms;
   logic [9:0]  e;
   logic [7:0]  d;
   logic        nbig, nsml, ibig, isml;

   // Orders the operands by magnitude, aligns, adds and renormalises.
   always_comb begin
      big = (a[30:0] >= b[30:0]) ? a : b;
      sml = (a[30:0] >= b[30:0]) ? b : a;
      nbig = (big[30:23] == 8'hFF) && (big[22:0] != 23'h0);
      nsml = (sml[30:23] == 8'hFF) && (sml[22:0] != 23'h0);
      ibig = (big[30:23] == 8'hFF) && !nbig;
      isml = (sml[30:23] == 8'hFF) && !nsml;
      d = big[30:23] - sml[30:23];
      e = {2'h0, big[30:23]};
      ms = (sml[30:23] == 8'h00 || d > 8'h18) ? 25'h0 : ({2'h1, sml[22:0]} >> d);
      s = (big[31] == sml[31]) ? {2'h1, big[22:0]} + ms : {2'h1, big[22:0]} - ms;
      if (s[24]) begin
         s = s >> 1;
         e = e + 10'h001;
      end
      for (int i = 0; i < 24; i++) begin
         if (!s[23] && s != 25'h0) begin
            s = s << 1;
            e = e - 10'h001;
         end
      end
      if (nbig || nsml || (ibig && isml && big[31] != sml[31])) begin
         y = `TDS_FP_QNAN;
      end else if (ibig || (!e[9] && e >= 10'h0FF)) begin
         y = {big[31], 8'hFF, 23'h0};
      end else if (big[30:23] == 8'h00) begin
         y = 32'h0;
      end else if (s == 25'h0 || e[9] || e == 10'h000) begin
         y = 32'h0;
      end else begin
         y = {big[31], e[7:0], s[22:0]};
      end
   end
endmodule

// *** src/tds_setup.sv ***
/*
 Triangle-class primitive decomposition and the front of object setup:
 NaN culling, viewport scale and translate, sampling-grid origin bias and
 completion of rectangles. Control and the viewport table sit on APB.
 Assumes one clock, synchronous inputs and APB master behaviour.
*/
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "tds_map.svh"
module tds_setup
   import tds_pkg::*;
(
   // Clock, reset and clock enable.
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire logic         ce,
   // APB register port.
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   // Vertex stream from the geometry stage.
   input  wire logic         vin_valid,
   output logic              vin_ready,
   input  wire tds_vin_t     vin,
   // Object stream to the rasterizer stage.
   output logic              obj_valid,
   input  wire logic         obj_ready,
   output tds_obj_t          obj
);
   typedef enum logic [1:0] {S_IDLE, S_XFORM, S_SEND} tds_state_t;

   tds_state_t   state_r, state_nxt;
   logic [5:0]   ctrl_r;
   logic [15:0]  cull_cnt_r;
   logic [31:0]  vp_mem [`TDS_VP_ENTRIES][`TDS_VP_ELEMS];
   logic         apb_acc, apb_ok;
   logic [31:0]  rd_nxt;
   tds_vtx_t     anc_r, w0_r, w1_r;
   tds_topo_t    topo_r, topo_eff;
   logic [1:0]   cnt_r, cnt_eff, ph_r, ph_eff;
   logic         inv_r, inv_eff, take, dec_emit;
   tds_obj_t     obj_r, obj_nxt;
   logic [1:0]   xi_r;
   logic         cull_r, cull_v;
   tds_vtx_t     wk_r [3];
   tds_vtx_t     cur, fin;
   logic [31:0]  pin [3], sc [3], tr [3], mo [3], ao [3], pos [3], bo [2];

   // True when a single-precision word holds a NaN.
   function automatic logic nan32(input logic [31:0] f);
      nan32 = (f[30:23] == 8'hFF) && (f[22:0] != 23'h0);
   endfunction

   // True when the address names a viewport table word.
   function automatic logic vp_hit(input logic [11:0] a);
      vp_hit = (a[11:9] == `TDS_VP_PAGE) && (a[4:2] < 3'(`TDS_VP_ELEMS))
               && (a[1:0] == 2'h0);
   endfunction

   // True when any vertex of the first three holds a NaN position.
   function automatic logic obj_nan(input tds_obj_t o);
      obj_nan = 1'b0;
      for (int i = 0; i < 3; i++) begin
         obj_nan = obj_nan | nan32(o.v[i].x) | nan32(o.v[i].y)
                   | nan32(o.v[i].z) | nan32(o.v[i].reciprocal_w);
      end
   endfunction

   // Register answers are formed during the setup cycle of a transfer.
   assign apb_acc = psel && penable && pready;
   always_comb begin
      apb_ok = 1'b1;
      rd_nxt = 32'h0;
      if (paddr == `TDS_ADDR_CTRL) begin
         rd_nxt = {26'h0, ctrl_r};
      end else if (paddr == `TDS_ADDR_STAT) begin
         rd_nxt = {cull_cnt_r, 15'h0, state_r != S_IDLE};
      end else if (vp_hit(paddr)) begin
         rd_nxt = vp_mem[paddr[8:5]][paddr[4:2]];
      end else begin
         apb_ok = 1'b0;
      end
   end

   // Bus answer: no wait state, ready with data and error flag in the first access cycle.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= psel && !penable && !pready;
         prdata  <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0;
         pslverr <= psel && !penable && !apb_ok;
      end
   end

   // Control register: viewport enable, origin bias and provoking selects.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl_r <= `TDS_CTRL_RST;
      end else if (ce && apb_acc && pwrite && paddr == `TDS_ADDR_CTRL) begin
         ctrl_r <= pwdata[5:0];
      end
   end

   // Viewport matrix table, written by software before use.
   always_ff @(posedge clk_sys) begin
      if (ce && apb_acc && pwrite && vp_hit(paddr)) begin
         vp_mem[paddr[8:5]][paddr[4:2]] <= pwdata;
      end
   end

   // Effective primitive context: a first vertex restarts every count.
   assign take     = vin_valid && vin_ready;
   assign topo_eff = vin.first ? vin.topo : topo_r;
   assign cnt_eff  = vin.first ? 2'h0 : cnt_r;
   assign ph_eff   = vin.first ? 2'h0 : ph_r;
   assign inv_eff  = vin.first ? (vin.topo == topo_triangle_strip_rev) : inv_r;

   // Object formation from the vertex window and the new vertex.
   always_comb begin
      dec_emit = 1'b0;
      obj_nxt  = '0;
      obj_nxt.obj_kind         = obj_kind_triangle;
      obj_nxt.obj_vertex_count = `TDS_NV_TRI;
      obj_nxt.poly_stipple_flag = 1'b1;
      obj_nxt.v[0] = w0_r;
      obj_nxt.v[1] = w1_r;
      obj_nxt.v[2] = vin.vtx;
      case (topo_eff)
         topo_triangle_list: begin
            dec_emit = ph_eff == `TDS_GRP_LAST;
            obj_nxt.provoking_index = ctrl_r[`TDS_CTRL_PLS +: 2];
         end
         topo_rectangle_list: begin
            dec_emit = ph_eff == `TDS_GRP_LAST;
            obj_nxt.obj_kind = obj_kind_rectangle;
         end
         topo_triangle_strip, topo_triangle_strip_rev: begin
            dec_emit = cnt_eff == 2'h2;
            obj_nxt.winding_invert_flag = inv_eff;
            obj_nxt.provoking_index = ctrl_r[`TDS_CTRL_PLS +: 2];
         end
         topo_triangle_fan, topo_fan_no_stipple, topo_polygon: begin
            dec_emit = cnt_eff == 2'h2;
            obj_nxt.v[0] = anc_r;
            obj_nxt.poly_stipple_flag = topo_eff != topo_fan_no_stipple;
            obj_nxt.provoking_index = (topo_eff == topo_polygon) ? 2'h0
                                      : ctrl_r[`TDS_CTRL_PFAN +: 2];
         end
         default: begin
            dec_emit = 1'b0;
         end
      endcase
   end

   // Vertex window: anchor, previous two vertices, counts and winding.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         topo_r <= topo_triangle_list;
         cnt_r  <= 2'h0;
         ph_r   <= 2'h0;
         inv_r  <= 1'b0;
         anc_r  <= '0;
         w0_r   <= '0;
         w1_r   <= '0;
      end else if (ce && take) begin
         topo_r <= topo_eff;
         cnt_r  <= (cnt_eff == 2'h2) ? 2'h2 : cnt_eff + 2'h1;
         ph_r   <= (ph_eff == `TDS_GRP_LAST) ? 2'h0 : ph_eff + 2'h1;
         inv_r  <= dec_emit ? !inv_eff : inv_eff;
         if (vin.first) begin
            anc_r <= vin.vtx;
         end
         w0_r <= w1_r;
         w1_r <= vin.vtx;
      end
   end

   // Per-vertex transform datapath on the vertex being worked on.
   assign cur = obj_r.v[xi_r];
   assign pin[0] = cur.x;
   assign pin[1] = cur.y;
   assign pin[2] = cur.z;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_axis
         assign sc[g] = vp_mem[obj_r.v[0].viewport_select][g];
         assign tr[g] = vp_mem[obj_r.v[0].viewport_select][g + 3];
         tds_fp_mul u_mul (.a(pin[g]), .b(sc[g]), .y(mo[g]));
         tds_fp_add u_add (.a(mo[g]), .b(tr[g]), .y(ao[g]));
         assign pos[g] = ctrl_r[`TDS_CTRL_VPEN] ? ao[g] : pin[g];
      end
      for (g = 0; g < 2; g++) begin : g_bias
         tds_fp_add u_bias (.a(pos[g]), .b(`TDS_FP_MHALF), .y(bo[g]));
      end
   endgenerate

   // Final vertex: origin bias shifts X and Y by one half when selected.
   always_comb begin
      fin   = cur;
      fin.x = ctrl_r[`TDS_CTRL_BIAS] ? bo[0] : pos[0];
      fin.y = ctrl_r[`TDS_CTRL_BIAS] ? bo[1] : pos[1];
      fin.z = pos[2];
      cull_v = nan32(cur.x) | nan32(cur.y) | nan32(cur.z)
               | nan32(cur.reciprocal_w);
      if (ctrl_r[`TDS_CTRL_VPEN]) begin
         cull_v = cull_v | nan32(ao[0]) | nan32(ao[1]) | nan32(ao[2]);
      end
   end

   // Setup sequencer: one object at a time, three vertex steps, then send or discard.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (take && dec_emit) begin
               state_nxt = S_XFORM;
            end
         end
         S_XFORM: begin
            if (xi_r == 2'h2) begin
               state_nxt = (cull_r || cull_v) ? S_IDLE : S_SEND;
            end
         end
         S_SEND: begin
            if (obj_ready) begin
               state_nxt = S_IDLE;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // State, vertex step and accumulated discard flag.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_r <= S_IDLE;
         xi_r    <= 2'h0;
         cull_r  <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         xi_r    <= (state_r == S_XFORM) ? xi_r + 2'h1 : 2'h0;
         cull_r  <= (state_r == S_XFORM) && (cull_r || cull_v);
      end
   end

   // Decomposed object held while setup works on it.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         obj_r <= '0;
      end else if (ce && take && dec_emit) begin
         obj_r <= obj_nxt;
      end
   end

   // Worked vertices collected step by step.
   always_ff @(posedge clk_sys) begin
      if (ce && state_r == S_XFORM) begin
         wk_r[xi_r] <= fin;
      end
   end

   // Input ready from a flop: high only while setup will be idle.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         vin_ready <= 1'b0;
      end else if (ce) begin
         vin_ready <= state_nxt == S_IDLE;
      end
   end

   // Output object; rectangles gain the upper-right corner here.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         obj_valid <= 1'b0;
         obj       <= '0;
      end else if (ce) begin
         if (state_r == S_XFORM && state_nxt == S_SEND) begin
            obj_valid <= 1'b1;
            obj       <= obj_r;
            obj.v[0]  <= wk_r[0];
            obj.v[1]  <= wk_r[1];
            obj.v[2]  <= fin;
            if (obj_r.obj_kind == obj_kind_rectangle) begin
               obj.obj_vertex_count <= `TDS_NV_RECT;
               obj.v[3]   <= wk_r[0];
               obj.v[3].y <= fin.y;
            end
         end else if (state_r == S_SEND && obj_ready) begin
            obj_valid <= 1'b0;
         end
      end
   end

   // Count of discarded objects for software.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cull_cnt_r <= 16'h0;
      end else if (ce && state_r == S_XFORM && xi_r == 2'h2 && (cull_r || cull_v)) begin
         cull_cnt_r <= cull_cnt_r + 16'h1;
      end
   end

   // Checks next to the logic they guard.
   property p_hold;
      @(posedge clk_sys) disable iff (!resetn)
      obj_valid && !obj_ready && ce |=> obj_valid && $stable(obj);
   endproperty
   a_hold: assert property (p_hold) else $error("object changed while stalled");

   property p_list;
      @(posedge clk_sys) disable iff (!resetn)
      ce && take && dec_emit && topo_eff == topo_triangle_list
      |=> !obj_r.winding_invert_flag && obj_r.poly_stipple_flag;
   endproperty
   a_list: assert property (p_list) else $error("list object flags wrong");

   property p_strip0;
      @(posedge clk_sys) disable iff (!resetn)
      ce && take && vin.first && vin.topo == topo_triangle_strip_rev
      ##1 (ce && take && !vin.first) [*2]
      |-> dec_emit && obj_nxt.winding_invert_flag;
   endproperty
   a_strip0: assert property (p_strip0) else $error("reverse strip start wrong");

   property p_fan;
      @(posedge clk_sys) disable iff (!resetn)
      ce && take && dec_emit && topo_eff == topo_triangle_fan
      |=> !obj_r.winding_invert_flag && obj_r.v[0] == $past(anc_r);
   endproperty
   a_fan: assert property (p_fan) else $error("fan object wrong");

   property p_nostip;
      @(posedge clk_sys) disable iff (!resetn)
      ce && take && dec_emit && topo_eff == topo_fan_no_stipple
      |=> !obj_r.poly_stipple_flag;
   endproperty
   a_nostip: assert property (p_nostip) else $error("stipple not cleared");

   property p_poly;
      @(posedge clk_sys) disable iff (!resetn)
      ce && take && dec_emit && topo_eff == topo_polygon |=> obj_r.provoking_index == 2'h0;
   endproperty
   a_poly: assert property (p_poly) else $error("polygon provoking not zero");

   property p_rect;
      @(posedge clk_sys) disable iff (!resetn)
      obj_valid && obj.obj_kind == obj_kind_rectangle
      |-> obj.obj_vertex_count == `TDS_NV_RECT && obj.provoking_index == 2'h0
          && obj.v[3].x == obj.v[0].x && obj.v[3].y == obj.v[2].y;
   endproperty
   a_rect: assert property (p_rect) else $error("rectangle output wrong");

   property p_nonan;
      @(posedge clk_sys) disable iff (!resetn)
      obj_valid |-> !obj_nan(obj);
   endproperty
   a_nonan: assert property (p_nonan) else $error("NaN object not discarded");

   property p_seq;
      @(posedge clk_sys) disable iff (!resetn)
      ce && take && dec_emit |=> !vin_ready && !obj_valid;
   endproperty
   a_seq: assert property (p_seq) else $error("object order broken");
endmodule

// *** verif/tds_sink.sv ***
/*
 Rasterizer-side sink model for the object stream of the setup block.
 Assumes the clock of the block under test; the bench pops the queue.
*/
`timescale 1ns/1ps
module tds_sink
   import tds_pkg::*;
(
   // Clock and pacing mode.
   input  wire logic     clk_sys,
   input  wire logic     slow,
   // Object stream.
   input  wire logic     obj_valid,
   output logic          obj_ready,
   input  wire tds_obj_t obj
);
   tds_obj_t   q[$];
   logic [1:0] cnt_r = 2'h0;

   initial obj_ready = 1'b0;

   // Ready is withheld three cycles in four when slow, so the block must stall.
   always @(posedge clk_sys) begin
      cnt_r <= cnt_r + 2'h1;
      obj_ready <= !slow || (cnt_r == 2'h3);
      if (obj_valid && obj_ready) begin
         q.push_back(obj);
      end
   end
endmodule

// *** verif/tb_tds_setup.sv ***
/*
 Self-checking bench of the setup block: APB and vertex tasks, object checks.
 Assumes the sink model of tds_sink.sv on the object stream.
*/
`timescale 1ns/1ps
module tb_tds_setup;
   import tds_pkg::*;
   localparam logic [31:0] one_f = 32'h3F800000;
   logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
   logic        vin_valid, vin_ready, obj_valid, obj_ready, slow, ce;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   tds_vin_t    vin;
   tds_obj_t    obj, o;
   int          bad_count, n_checks, i;
   tds_topo_t   fan_topo [3] = '{topo_triangle_fan, topo_fan_no_stipple, topo_polygon};
   logic [7:0]  fan_flag [3] = '{8'h35, 8'h31, 8'h34};
   logic [31:0] vp_val [6] = '{32'h40000000, one_f, one_f, one_f, 32'h0, 32'h0};

   tds_setup u_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .vin_valid(vin_valid), .vin_ready(vin_ready),
      .vin(vin), .obj_valid(obj_valid), .obj_ready(obj_ready), .obj(obj));
   tds_sink u_sink (.clk_sys(clk_sys), .slow(slow), .obj_valid(obj_valid),
      .obj_ready(obj_ready), .obj(obj));

   // Free-running 125 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Compares one value and counts the outcome.
   task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // One APB transfer; d is write data or expected read data.
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic err);
      int k;
      logic [32:0] seen;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      seen = {pslverr, w ? d : prdata};
      psel <= 1'b0;
      penable <= 1'b0;
      chk("apb", {err, d}, seen);
      if (k == 50) begin
         bad_count++;
         close_out();
      end
   endtask

   // Sends one primitive of n vertices whose attributes count up from base.
   task automatic prim(tds_topo_t t, int n, logic [15:0] base, logic [31:0] x, logic [3:0] vs);
      int k;
      @(posedge clk_sys);
      for (int j = 0; j < n; j++) begin
         vin_valid <= 1'b1;
         vin <= '{first: 1'(j == 0), topo: t,
                  vtx: '{x, one_f, one_f, one_f, vs, base + 16'(j)}};
         for (k = 0; k < 300; k++) begin
            @(posedge clk_sys);
            if (vin_ready === 1'b1) break;
         end
         if (k == 300) begin
            bad_count++;
            close_out();
         end
      end
      vin_valid <= 1'b0;
   endtask

   // Takes the next object from the sink and checks flags and vertex choice.
   task automatic obj_chk(logic [7:0] fl, logic [15:0] a0, logic [15:0] a1, logic [15:0] a2);
      int k;
      for (k = 0; k < 400 && u_sink.q.size() == 0; k++) @(negedge clk_sys);
      if (k == 400) begin
         bad_count++;
         close_out();
      end
      o = u_sink.q.pop_front();
      chk("flags", fl, {o.obj_kind, o.obj_vertex_count, o.winding_invert_flag,
                        o.poly_stipple_flag, o.provoking_index});
      chk("vertices", {a0, a1, a2}, {o.v[0].attr, o.v[1].attr, o.v[2].attr});
   endtask

   // Main sequence.
   initial begin
      {resetn, psel, penable, pwrite, paddr, pwdata, vin_valid, vin, slow} = '0;
      ce = 1'b1;
      bad_count = 0;
      n_checks = 0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 1'b1);
      apb(1'b1, 12'h000, 32'h00000018, 1'b0);
      apb(1'b0, 12'h000, 32'h00000018, 1'b0);
      slow <= 1'b1;
      // Seven list vertices: two objects, the tail vertex is dropped.
      prim(topo_triangle_list, 7, 16'h0010, one_f, 4'h0);
      obj_chk(8'h36, 16'h0010, 16'h0011, 16'h0012);
      obj_chk(8'h36, 16'h0013, 16'h0014, 16'h0015);
      prim(topo_triangle_strip_rev, 5, 16'h0020, one_f, 4'h0);
      for (i = 0; i < 3; i++) begin
         obj_chk(i[0] ? 8'h36 : 8'h3E, 16'h20 + 16'(i), 16'h21 + 16'(i), 16'h22 + 16'(i));
      end
      prim(topo_triangle_strip, 3, 16'h0028, one_f, 4'h0);
      // Clock enable low for two cycles in mid-setup: the object must come out intact.
      ce <= 1'b0;
      repeat (2) @(posedge clk_sys);
      ce <= 1'b1;
      obj_chk(8'h36, 16'h0028, 16'h0029, 16'h002A);
      for (i = 0; i < 3; i++) begin
         prim(fan_topo[i], 4, 16'h0030 + 16'(i * 16), one_f, 4'h0);
         obj_chk(fan_flag[i], 16'h30 + 16'(i * 16), 16'h31 + 16'(i * 16), 16'h32 + 16'(i * 16));
         obj_chk(fan_flag[i], 16'h30 + 16'(i * 16), 16'h32 + 16'(i * 16), 16'h33 + 16'(i * 16));
      end
      prim(topo_rectangle_list, 3, 16'h0060, one_f, 4'h0);
      obj_chk(8'hC4, 16'h0060, 16'h0061, 16'h0062);
      chk("rect x", one_f, o.v[0].x);
      // A NaN object is dropped and counted; the next one still follows in order.
      prim(topo_triangle_list, 3, 16'h0070, 32'h7FC00000, 4'h0);
      prim(topo_triangle_list, 3, 16'h0080, one_f, 4'h0);
      obj_chk(8'h36, 16'h0080, 16'h0081, 16'h0082);
      apb(1'b0, 12'h004, 32'h00010000, 1'b0);
      // Viewport entry 1 doubles X and adds one; half bias is on.
      for (i = 0; i < 6; i++) apb(1'b1, 12'h220 + 12'(i * 4), vp_val[i], 1'b0);
      apb(1'b1, 12'h000, 32'h0000001B, 1'b0);
      prim(topo_triangle_list, 3, 16'h0090, one_f, 4'h1);
      obj_chk(8'h36, 16'h0090, 16'h0091, 16'h0092);
      chk("vp x", 32'h40200000, o.v[2].x);
      chk("vp y", 32'h3F000000, o.v[0].y);
      apb(1'b0, 12'h22C, one_f, 1'b0);
      // An infinite X scale on a zero X gives NaN after the transform: discarded.
      apb(1'b1, 12'h220, 32'h7F800000, 1'b0);
      prim(topo_triangle_list, 3, 16'h00A0, 32'h0, 4'h1);
      repeat (8) @(posedge clk_sys);
      chk("sink queue", 64'h0, u_sink.q.size());
      apb(1'b0, 12'h004, 32'h00020000, 1'b0);
      close_out();
   end
endmodule
